// ### verilog/rtc_dcal_pkg.sv
// Constants and helpers shared by the digital calibration block
package rtc_dcal_pkg;
	localparam int unsigned OSC_HZ       = 32_768;       // Nominal crystal rate
	localparam int unsigned TAP_HZ       = 512;          // Rate of the upstream tap
	localparam logic [5:0]  PRESCALE_MAX = 6'(OSC_HZ / TAP_HZ - 1);
	localparam logic [9:0]  PULSES_SEC   = 10'h064;      // Output pulses per second
	localparam logic [9:0]  RATIO_NORM   = 10'h200;      // 512 taps per second
	localparam logic [9:0]  RATIO_FAST   = 10'h1ff;      // 511 taps, speeds up
	localparam logic [9:0]  RATIO_SLOW   = 10'h201;      // 513 taps, slows down
	localparam logic [9:0]  CYCLE_FAST_S = 10'h1e0;      // Eight minutes of seconds
	localparam logic [9:0]  CYCLE_SLOW_S = 10'h3c0;      // Sixteen minutes of seconds
	localparam logic [7:0]  ADDR_FRAC    = 8'h00;        // Hundredths, BCD
	localparam logic [7:0]  ADDR_DCAL    = 8'h08;        // Calibration control
	localparam logic [7:0]  ADDR_POS_LO  = 8'h0c;        // Cycle position, low byte
	localparam logic [7:0]  ADDR_POS_HI  = 8'h10;        // Cycle position high, status
	localparam logic [7:0]  DCAL_RESET   = 8'h00;        // Control value after reset
	localparam int unsigned MAG_MSB      = 4;            // Magnitude is bits 4..0
	localparam int unsigned SIGN_BIT     = 5;            // Direction of correction
	localparam int unsigned FT_BIT       = 6;            // Test tap enable
	localparam int unsigned OUT_BIT      = 7;            // Static pin level
	localparam logic [3:0]  BCD_NINE     = 4'h9;         // Last decimal digit

	// Taps per second for a plain or a correcting second
	function automatic logic [9:0] rtc_dcal_len(input logic on, input logic fast);
		return on ? (fast ? RATIO_FAST : RATIO_SLOW) : RATIO_NORM;
	endfunction
endpackage

// ### verilog/rtc_dcal_if.sv
`timescale 1ns/1ns
// Signals between the prescaler, the correction divider and the control logic
interface rtc_dcal_if;
	logic       tick512;  // One-cycle pulse per 512 Hz period
	logic       sq512;    // 512 Hz square wave, uncorrected
	logic [9:0] win_len;  // Taps in the current second
	logic       pulse100; // One-cycle pulse of the 100 Hz stage
	logic       sec_end;  // One-cycle pulse at the end of a second
	modport osc (output tick512, output sq512);
	modport div (input tick512, input win_len, output pulse100, output sec_end);
	modport ctl (input sq512, input pulse100, input sec_end, output win_len);
endinterface

// ### verilog/rtc_dcal_osc.sv
`timescale 1ns/1ns
// Crystal input synchroniser and divide-by-64 prescaler to the 512 Hz stage
module rtc_dcal_osc
	import rtc_dcal_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic osc_i,
	rtc_dcal_if.osc   lnk
);
	logic [2:0] osc_sync; // Three-stage synchroniser, bit 0 first
	logic       osc_lvl;  // Accepted crystal level
	logic       osc_rise; // Accepted rising edge
	logic [5:0] pre_cnt;  // Crystal periods within one tap period

	// Shift the crystal level in
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			osc_sync <= 3'h0;
		end else begin
			osc_sync <= {osc_sync[1:0], osc_i};
		end
	end

	// A new level counts once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			osc_lvl <= 1'b0;
		end else if (osc_sync[1] == osc_sync[2]) begin
			osc_lvl <= osc_sync[2];
		end
	end

	assign osc_rise = osc_sync[1] & osc_sync[2] & ~osc_lvl;

	// Divide the crystal down to the 512 Hz stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_cnt     <= 6'h00;
			lnk.tick512 <= 1'b0;
		end else begin
			if (osc_rise) begin
				pre_cnt <= pre_cnt + 6'h01;
			end
			lnk.tick512 <= osc_rise && (pre_cnt == PRESCALE_MAX);
		end
	end

	// Square wave taken ahead of any correction
	assign lnk.sq512 = pre_cnt[5];

	tap_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lnk.tick512 |-> (pre_cnt == 6'h00) && $past(pre_cnt) == PRESCALE_MAX)
		else $error("512 Hz tick not at prescaler wrap");
endmodule

// ### verilog/rtc_dcal_div.sv
`timescale 1ns/1ns
// Fractional divider from the 512 Hz stage to the 100 Hz stage
module rtc_dcal_div
	import rtc_dcal_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	rtc_dcal_if.div   lnk
);
	logic [9:0]  acc;  // Remainder of pulses owed
	logic [9:0]  idx;  // Tap index within the second
	logic [10:0] sum;  // Remainder plus one tap's share
	logic        hit;  // This tap yields an output pulse
	logic        last; // This tap closes the second
	logic [6:0]  seen; // Pulses so far in the second, checking only

	// Spread exactly 100 pulses over the taps of one second
	always_comb begin
		sum  = {1'b0, acc} + {1'b0, PULSES_SEC};
		hit  = (sum >= {1'b0, lnk.win_len});
		last = (idx == lnk.win_len - 10'h001);
	end

	// Advance the remainder and index on each tap
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc <= 10'h000;
			idx <= 10'h000;
		end else if (lnk.tick512) begin
			idx <= last ? 10'h000 : idx + 10'h001;
			acc <= last ? 10'h000 : (hit ? 10'(sum - {1'b0, lnk.win_len}) : sum[9:0]);
		end
	end

	// Output pulses, one cycle each
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lnk.pulse100 <= 1'b0;
			lnk.sec_end  <= 1'b0;
		end else begin
			lnk.pulse100 <= lnk.tick512 && hit;
			lnk.sec_end  <= lnk.tick512 && last;
		end
	end

	// Pulse tally for the check below
	always_ff @(posedge clk_i) begin
		if (rst_i || lnk.sec_end) begin
			seen <= 7'h00;
		end else if (lnk.pulse100) begin
			seen <= seen + 7'h01;
		end
	end

	hundred_per_sec_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lnk.sec_end |-> lnk.pulse100 && (seen == 7'h63))
		else $error("Second did not carry exactly 100 pulses");
endmodule

// ### verilog/rtc_dcal_top.sv
`timescale 1ns/1ns
// Digital calibration: 512 Hz to 100 Hz divider with periodic correction
// Notes on behaviour
// - 32768 Hz crystal divided to 512 Hz stage
// - Uncorrected: 100 pulses per 512 taps
// - 100 Hz pulses clock the hundredths counter
// - Positive correcting second: 100 per 511
// - Negative correcting second: 100 per 513
// - Zero magnitude: never correct, any sign
// - First N seconds of 8/16-minute cycle
// - Magnitude 0..31 in low five bits
// - Sixth bit: 1 speeds, 0 slows
// - Step worth +4.068 or -2.034 ppm
// - Test enable drives 512 Hz on pin
// - Test tap ahead of the correction
module rtc_dcal_top
	import rtc_dcal_pkg::*;
(
	input  wire logic       clk_i,             // System clock
	input  wire logic       rst_i,             // Synchronous reset
	input  wire logic       osc_i,             // Crystal oscillator level
	input  wire logic [7:0] addr_i,            // Register address
	input  wire logic [7:0] wdata_i,           // Write data
	input  wire logic       wr_i,              // Write strobe
	input  wire logic       rd_i,              // Read strobe
	output logic      [7:0] rdata_o,           // Read data, cycle after strobe
	output logic            shared_irq_test_pin_o, // Test tap or static level
	output logic            hundredths_tick_o, // 100 Hz pulse
	output logic            second_tick_o,     // End of second pulse
	output logic            correcting_o       // Current second is corrected
);
	// Register decode used by the write path and the read-back check
	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	rtc_dcal_if lnk (); // Internal link between the parts

	logic [7:0] dcal;          // Calibration control register
	logic [4:0] mag;           // Correction magnitude
	logic       sign;          // Correction sign
	logic       ft_en;         // Test tap enable
	logic       out_lvl;       // Static pin level
	logic [3:0] frac_lo;       // Hundredths digit
	logic [3:0] frac_hi;       // Tenths digit
	logic [9:0] pos;           // Second within the correction cycle
	logic [9:0] cyc_lim;       // Seconds in the current cycle
	logic [9:0] next_pos;      // Position of the coming second
	logic       next_on;       // Coming second is corrected
	logic       corr_cur;      // Current second is corrected
	logic [9:0] win_len;       // Taps in the current second

	// Field views of the control register
	assign mag     = dcal[MAG_MSB:0];
	assign sign    = dcal[SIGN_BIT];
	assign ft_en   = dcal[FT_BIT];
	assign out_lvl = dcal[OUT_BIT];

	// Prescaler from the crystal to the 512 Hz stage
	rtc_dcal_osc u_osc (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.osc_i (osc_i),
		.lnk   (lnk.osc)
	);

	// Correction divider to the 100 Hz stage
	rtc_dcal_div u_div (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.lnk   (lnk.div)
	);

	assign lnk.win_len = win_len;

	// Control register write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dcal <= DCAL_RESET;
		end else if (wr_i && reg_hit(addr_i, ADDR_DCAL)) begin
			// Correction fields apply from the next second boundary, pin fields at once
			dcal <= wdata_i;
		end
	end

	// Cycle length and the next second's position
	always_comb begin
		// Eight minutes when speeding up, sixteen when slowing down
		cyc_lim  = sign ? CYCLE_FAST_S : CYCLE_SLOW_S;
		// Wrap also covers a sign change that shortens the cycle
		next_pos = (pos >= cyc_lim - 10'h001) ? 10'h000 : pos + 10'h001;
		// Correct only the first N seconds, never with N zero
		next_on  = (mag != 5'h00) && (next_pos < {5'h00, mag});
	end

	// Second position within the cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pos <= 10'h000;
		end else if (lnk.sec_end) begin
			// Position runs on through writes, so a rewrite mid cycle
			// only takes full effect when software keeps to the pace
			pos <= next_pos;
		end
	end

	// Ratio of the coming second, fixed at its start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			win_len  <= RATIO_NORM;
			corr_cur <= 1'b0;
		end else if (lnk.sec_end) begin
			// One tap per correcting second, N seconds per cycle,
			// gives steps of 1/512 s over 480 s or 960 s
			win_len  <= rtc_dcal_len(next_on, sign);
			corr_cur <= next_on;
		end
	end

	// Hundredths counter clocked by the 100 Hz stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frac_lo <= 4'h0;
			frac_hi <= 4'h0;
		end else if (lnk.pulse100) begin
			if (frac_lo == BCD_NINE) begin
				// Carry into tenths, wrapping after 99
				frac_lo <= 4'h0;
				frac_hi <= (frac_hi == BCD_NINE) ? 4'h0 : frac_hi + 4'h1;
			end else begin
				// Plain count within the digit
				frac_lo <= frac_lo + 4'h1;
			end
		end
	end

	// Shared pin: uncorrected tap when enabled, else the static level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shared_irq_test_pin_o <= 1'b0;
		end else begin
			shared_irq_test_pin_o <= ft_en ? lnk.sq512 : out_lvl;
		end
	end

	// Pulse and status outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hundredths_tick_o <= 1'b0;
			second_tick_o     <= 1'b0;
			correcting_o      <= 1'b0;
		end else begin
			hundredths_tick_o <= lnk.pulse100;
			second_tick_o     <= lnk.sec_end;
			correcting_o      <= corr_cur;
		end
	end

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			unique case (addr_i)
				// Hundredths in BCD
				ADDR_FRAC:   rdata_o <= {frac_hi, frac_lo};
				// Control register as written
				ADDR_DCAL:   rdata_o <= dcal;
				// Low bits of the cycle position
				ADDR_POS_LO: rdata_o <= pos[7:0];
				// Correction state and top position bits
				ADDR_POS_HI: rdata_o <= {corr_cur, 5'h00, pos[9:8]};
				// Unmapped addresses read as zero
				default:     rdata_o <= 8'h00;
			endcase
		end else begin
			// Data stands for one cycle only
			rdata_o <= 8'h00;
		end
	end

	// Checks on the control logic

	frac_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lnk.sec_end |=> (frac_lo == 4'h0) && (frac_hi == 4'h0))
		else $error("Hundredths not at zero after a second");

	fast_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lnk.sec_end && next_on && sign |=> win_len == RATIO_FAST)
		else $error("Positive correcting second not 511 taps");

	slow_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lnk.sec_end && next_on && !sign |=> win_len == RATIO_SLOW)
		else $error("Negative correcting second not 513 taps");

	zero_mag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lnk.sec_end && (mag == 5'h00) |=> !corr_cur && (win_len == RATIO_NORM))
		else $error("Correction applied with zero magnitude");

	first_secs_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lnk.sec_end && (mag != 5'h00) |=> corr_cur == (pos < {5'h00, $past(mag)}))
		else $error("Correction not in first N seconds");

	cycle_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lnk.sec_end && (pos == cyc_lim - 10'h001) |=> pos == 10'h000)
		else $error("Cycle position did not wrap");

	pos_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lnk.sec_end |=> pos < CYCLE_SLOW_S)
		else $error("Cycle position beyond sixteen minutes");

	dcal_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && reg_hit(addr_i, ADDR_DCAL) && !wr_i |=> rdata_o == dcal)
		else $error("Calibration register read back wrong");

	sign_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lnk.sec_end && next_on |=> win_len == ($past(sign) ? RATIO_FAST : RATIO_SLOW))
		else $error("Sign bit selected wrong direction");

	test_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ft_en |=> shared_irq_test_pin_o == $past(lnk.sq512))
		else $error("Test pin does not follow the 512 Hz tap");
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the digital calibration block
module tb_top;
	import rtc_dcal_pkg::*;

	logic       clk_i   = 1'b0;  // System clock
	logic       rst_i   = 1'b1;  // Synchronous reset
	logic       osc_i   = 1'b0;  // Fast stand-in for the crystal
	logic [7:0] addr_i  = 8'h00; // Register address
	logic [7:0] wdata_i = 8'h00; // Write data
	logic       wr_i    = 1'b0;  // Write strobe
	logic       rd_i    = 1'b0;  // Read strobe
	logic [7:0] rdata_o;         // Read data
	logic       pin_o;           // Test tap or static level
	logic       hund_o;          // Hundredths pulse
	logic       sec_o;           // End of second pulse
	logic       corr_o;          // Correcting second
	int         bad_count = 0;   // Mismatches seen
	int         tests_run = 0;   // Comparisons made
	int         seed      = 32'h3e99;
	int         gap_q[$];        // Clocks between second ticks
	int         hun_q[$];        // Hundredths pulses per second
	int         gap_cnt   = 0;   // Clocks since last second tick
	int         hun_cnt   = 0;   // Pulses since last second tick
	logic [7:0] dcal_model = DCAL_RESET; // Model of the control register
	int         osc_div   = 0;   // Clock count for the crystal stand-in

	rtc_dcal_top u_dut (
		.clk_i                 (clk_i),
		.rst_i                 (rst_i),
		.osc_i                 (osc_i),
		.addr_i                (addr_i),
		.wdata_i               (wdata_i),
		.wr_i                  (wr_i),
		.rd_i                  (rd_i),
		.rdata_o               (rdata_o),
		.shared_irq_test_pin_o (pin_o),
		.hundredths_tick_o     (hund_o),
		.second_tick_o         (sec_o),
		.correcting_o          (corr_o)
	);

	// Clock of 10 ns
	always #5 clk_i = ~clk_i;

	// Crystal stand-in: four clocks a period, the fastest the filter accepts
	always @(posedge clk_i) begin
		osc_div <= osc_div + 1;
		if (osc_div[0]) begin
			osc_i <= ~osc_i;
		end
	end

	// Measures every second between ticks
	always @(posedge clk_i) begin
		if (rst_i) begin
			gap_cnt = 0;
			hun_cnt = 0;
		end else begin
			gap_cnt++;
			if (hund_o === 1'b1) begin
				hun_cnt++;
			end
			if (sec_o === 1'b1) begin
				gap_q.push_back(gap_cnt);
				hun_q.push_back(hun_cnt);
				gap_cnt = 0;
				hun_cnt = 0;
			end
		end
	end

	// Prints the counts and the verdict, then stops
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Compares one value with its expectation
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One-cycle register write
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
		if (a == ADDR_DCAL) begin
			dcal_model = d;
		end
	endtask

	// One-cycle register read, data taken in the following cycle
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	// Waits until n second ticks have been seen
	task automatic wait_secs(input int n);
		int k;
		k = 0;
		while (gap_q.size() < n && k < 200000) begin
			@(posedge clk_i);
			k++;
		end
		if (gap_q.size() < n) begin
			bad_count++;
			$display("[FAIL] second tick expected %0d seen %0d", n, gap_q.size());
			complete_run();
		end
	endtask

	// Clocks up to the next rising edge of the test pin
	task automatic pin_rise(output int k);
		k = 0;
		while (pin_o !== 1'b0 && k < 400) begin
			@(posedge clk_i);
			k++;
		end
		while (pin_o !== 1'b1 && k < 400) begin
			@(posedge clk_i);
			k++;
		end
	endtask

	// Main sequence
	initial begin
		logic [7:0] rd_val;
		logic [7:0] rnd;
		logic [7:0] pend;
		logic [7:0] next_ctl [3];
		logic       exp_corr;
		int         exp_len;
		int         k;
		next_ctl = '{8'h63, 8'h44, 8'h40};
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		// Register access with a random value and an unmapped address
		reg_rd(ADDR_DCAL, rd_val);
		check("dcal reset", rd_val, DCAL_RESET);
		rnd = 8'($random(seed));
		reg_wr(ADDR_DCAL, rnd);
		reg_wr(8'h09, ~rnd);
		reg_rd(ADDR_DCAL, rd_val);
		check("dcal readback", rd_val, dcal_model);
		reg_rd(8'h09, rd_val);
		check("unmapped read", rd_val, 8'h00);
		// Sign set with zero magnitude governs the first full second
		reg_wr(ADDR_DCAL, {rnd[7], 1'b0, 1'b1, 5'h00});
		repeat (4) @(posedge clk_i);
		check("static pin", pin_o, dcal_model[OUT_BIT]);
		$display("register test done");
		for (int s = 1; s <= 3; s++) begin
			wait_secs(s);
			pend = dcal_model;
			reg_wr(ADDR_DCAL, next_ctl[s-1]);
			repeat (200) @(posedge clk_i);
			exp_corr = (pend[4:0] != 5'h00) && (s < int'(pend[4:0]));
			check("correcting", corr_o, exp_corr);
			if (dcal_model[FT_BIT]) begin
				pin_rise(k);
				for (int p = 0; p < 3; p++) begin
					pin_rise(k);
					check("tap period", k, 256);
				end
			end
			wait_secs(s + 1);
			exp_len = exp_corr ? (pend[SIGN_BIT] ? 511 : 513) : 512;
			check("second length", gap_q[s], 256 * exp_len);
			check("hundredths", hun_q[s], 100);
			$display("second %0d test done", s);
		end
		complete_run();
	end

	// Watchdog against a hang
	initial begin
		#7_000_000;
		bad_count++;
		$display("[FAIL] run end expected before limit seen timeout");
		complete_run();
	end
endmodule
